// ===== core/power_down_mode_control.sv
// Power-down mode controller: Sleep, Idle, Doze and wake-up handling
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "pdm_map.svh"

// Summary of operation
// R1 - Race applies with global enable clear, source pending
// R2 - Pending before halt: halt is a no-op
// R3 - Halt completes, wakes, clears watchdog, flags updated
// R4 - Global enable set: one instruction, then vector
// R5 - Regulator low-power in Sleep when selected
// R6 - Regulator register bit zero reads one
// R7 - Idle select chooses Idle over Sleep
// R8 - Idle halts CPU, system-clock peripherals keep running
// R9 - Internal and secondary oscillator peripherals always run
// R10 - Clock output keeps toggling in Idle
// R11 - Any interrupt ends Idle, idle select kept
// R12 - Recover-on-interrupt restores full speed from Idle
// R13 - Watchdog expiry in Idle wakes, no reset
// R14 - Doze enable bit slows CPU, hardware may change
// R15 - Doze runs one cycle in 2^(code+1)
// R16 - Service entry copies doze bit, recover clears it
// R17 - Service return restores doze bit from copy
// R18 - Low-power wake waits regulator settle delay
module power_down_mode_control (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        halt_exec_in,
  input  wire logic        irq_pending_in,
  input  wire logic        global_irq_enable_in,
  input  wire logic        isr_entry_in,
  input  wire logic        isr_return_in,
  input  wire logic        wdt_expiry_in,
  input  wire logic        clock_output_pin_cfg_in,
  output logic             cpu_step_out,
  output logic             vector_req_out,
  output logic             wdt_clear_out,
  output logic             wdt_reset_out,
  output logic             regulator_low_power_out,
  output logic             sysclk_periph_run_out,
  output logic             intosc_periph_run_out,
  output logic             clock_output_run_out,
  output pdm_pkg::mode_type mode_out
);
  import pdm_pkg::*;

  ctl_state_type s_r;
  ctl_state_type s_nxt;
  doze_if        dz ();
  logic          req;
  logic          wr_en;
  logic          race_nop;
  logic          wr_doze;

  // Register hit on word index
  function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
    reg_hit = (adr[7:2] == idx);
  endfunction

  doze_pacer pacer (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .dz     (dz)
  );

  // Pacer steering
  assign dz.enable = s_r.doze_enable_bit; // R14
  assign dz.ratio  = s_r.ratio;
  assign dz.halted = (s_r.st != ST_RUN);

  // Bus qualifiers: write lands on the edge that sees ack
  assign req      = wb_cyc_in && wb_stb_in;
  assign wr_en    = req && wb_we_in && s_r.ack && wb_sel_in[0];
  assign wr_doze  = wr_en && reg_hit(wb_adr_in, `DOZE_OFF);
  assign race_nop = irq_pending_in && !global_irq_enable_in; // R1

  // Next-state logic for bus, registers and power mode
  always_comb begin
    s_nxt      = s_r;
    s_nxt.ack  = req && !s_r.ack;
    s_nxt.wclr = 1'b0;
    s_nxt.vreq = 1'b0;
    s_nxt.wrst = 1'b0;
    // Read data captured in the request cycle
    if (req && !s_r.ack) begin
      s_nxt.dat = 8'h00;
      if (reg_hit(wb_adr_in, `VREG_OFF)) begin
        s_nxt.dat[`VREG_LP_BIT]  = s_r.vlp;
        s_nxt.dat[`VREG_ONE_BIT] = 1'b1; // R6
      end else if (reg_hit(wb_adr_in, `DOZE_OFF)) begin
        s_nxt.dat = {s_r.idle_sel, s_r.doze_enable_bit, s_r.recover_on_irq, s_r.doe, 1'b0, s_r.ratio};
      end else if (reg_hit(wb_adr_in, `STAT_OFF)) begin
        s_nxt.dat[`STAT_EXP_BIT] = s_r.expf;
        s_nxt.dat[`STAT_PD_BIT]  = s_r.pdf;
      end
    end
    // Software writes; hardware updates below win
    if (wr_en && reg_hit(wb_adr_in, `VREG_OFF)) begin
      s_nxt.vlp = wb_dat_in[`VREG_LP_BIT];
    end
    if (wr_doze) begin
      s_nxt.idle_sel = wb_dat_in[`DOZE_IDLE_BIT];
      s_nxt.doze_enable_bit    = wb_dat_in[`DOZE_EN_BIT]; // R14
      s_nxt.recover_on_irq      = wb_dat_in[`DOZE_ROI_BIT];
      s_nxt.doe      = wb_dat_in[`DOZE_DOE_BIT];
      s_nxt.ratio    = wb_dat_in[2:0];
    end
    // Service entry and return
    if (isr_entry_in) begin
      s_nxt.doe = s_r.doze_enable_bit; // R16
      if (s_r.recover_on_irq) begin
        s_nxt.doze_enable_bit = 1'b0; // R16
      end
    end else if (isr_return_in) begin
      s_nxt.doze_enable_bit = s_r.doe; // R17
    end
    // Power mode sequence
    unique case (s_r.st)
      ST_RUN: begin
        if (wdt_expiry_in) begin
          s_nxt.wrst = 1'b1;
        end
        if (s_r.vec_pend && dz.step) begin
          s_nxt.vreq     = 1'b1; // R4
          s_nxt.vec_pend = 1'b0;
        end
        if (halt_exec_in && !race_nop) begin // R2
          s_nxt.wclr = 1'b1; // R3
          s_nxt.expf = 1'b1; // R3
          s_nxt.pdf  = 1'b0; // R3
          s_nxt.st   = s_r.idle_sel ? ST_IDLE : ST_SLEEP; // R7
        end
      end
      ST_SLEEP: begin
        if (irq_pending_in || wdt_expiry_in) begin
          s_nxt.wclr     = 1'b1;
          s_nxt.vec_pend = irq_pending_in && global_irq_enable_in; // R4
          if (!irq_pending_in) begin
            s_nxt.expf = 1'b0;
          end
          s_nxt.settle = 8'(`REG_SETTLE_CYC);
          s_nxt.st     = s_r.vlp ? ST_SETTLE : ST_RUN; // R18
        end
      end
      ST_IDLE: begin
        if (irq_pending_in) begin
          s_nxt.vec_pend = global_irq_enable_in;
          s_nxt.st       = ST_RUN; // R11
          if (s_r.recover_on_irq && s_r.doze_enable_bit) begin
            s_nxt.doze_enable_bit = 1'b0; // R12
          end
        end else if (wdt_expiry_in) begin
          s_nxt.expf = 1'b0;
          s_nxt.st   = ST_RUN; // R13
        end
      end
      ST_SETTLE: begin
        if (s_r.settle <= 8'h01) begin
          s_nxt.st = ST_RUN; // R18
        end
        s_nxt.settle = s_r.settle - 8'h01;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r      <= '0;
      s_r.st   <= ST_RUN;
      s_r.expf <= `EXPF_RST;
      s_r.pdf  <= `PDF_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign wb_ack_out              = s_r.ack;
  assign wb_dat_out              = {24'h000000, s_r.dat};
  assign cpu_step_out            = dz.step; // R8
  assign vector_req_out          = s_r.vreq;
  assign wdt_clear_out           = s_r.wclr;
  assign wdt_reset_out           = s_r.wrst;
  assign regulator_low_power_out = s_r.vlp && (s_r.st == ST_SLEEP); // R5
  assign sysclk_periph_run_out   = (s_r.st != ST_SLEEP); // R8
  assign intosc_periph_run_out   = 1'b1; // R9
  assign clock_output_run_out    = clock_output_pin_cfg_in && (s_r.st != ST_SLEEP); // R10
  assign mode_out                = s_r.st;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_race_nop_halt: assert property ( // R2
    s_r.st == ST_RUN && halt_exec_in && race_nop
    |=> s_r.st == ST_RUN && $stable(s_r.expf) && $stable(s_r.pdf) && !wdt_clear_out)
    else $error("halt with pending irq not treated as no-op");

  a_halt_flags_set: assert property ( // R3
    s_r.st == ST_RUN && halt_exec_in && !race_nop
    |=> wdt_clear_out && s_r.expf && !s_r.pdf)
    else $error("halt did not clear watchdog or update flags");

  a_idle_select_mode: assert property ( // R7
    s_r.st == ST_RUN && halt_exec_in && !race_nop
    |=> s_r.st == ($past(s_r.idle_sel) ? ST_IDLE : ST_SLEEP))
    else $error("halt entered wrong power mode");

  a_idle_irq_exit: assert property ( // R11
    s_r.st == ST_IDLE && irq_pending_in && !wr_doze
    |=> s_r.st == ST_RUN && $stable(s_r.idle_sel))
    else $error("interrupt did not end idle cleanly");

  a_roi_full_speed: assert property ( // R12
    s_r.st == ST_IDLE && irq_pending_in && s_r.recover_on_irq && s_r.doze_enable_bit && !wr_doze
    && !isr_return_in |=> !s_r.doze_enable_bit)
    else $error("recover-on-interrupt did not restore full speed");

  a_idle_wdt_wake: assert property ( // R13
    s_r.st == ST_IDLE && wdt_expiry_in && !irq_pending_in && !wr_doze
    && !isr_entry_in && !isr_return_in
    |=> s_r.st == ST_RUN && !wdt_reset_out && $stable(s_r.doze_enable_bit))
    else $error("watchdog expiry in idle mishandled");

  a_isr_doze_copy: assert property ( // R16
    isr_entry_in |=> s_r.doe == $past(s_r.doze_enable_bit) && !($past(s_r.recover_on_irq) && s_r.doze_enable_bit))
    else $error("service entry doze copy wrong");

  a_isr_doze_restore: assert property ( // R17
    isr_return_in && !isr_entry_in |=> s_r.doze_enable_bit == $past(s_r.doe))
    else $error("service return did not restore doze state");

  a_lp_settle_hold: assert property ( // R18
    s_r.st == ST_SLEEP && s_r.vlp && (irq_pending_in || wdt_expiry_in)
    |=> s_r.st == ST_SETTLE ##1 !cpu_step_out)
    else $error("low-power wake skipped regulator settle");

  a_vreg_bit_one: assert property ( // R6
    req && !s_r.ack && !wb_we_in && reg_hit(wb_adr_in, `VREG_OFF) |=> wb_dat_out[0])
    else $error("regulator register bit zero not read as one");

  a_sleep_regulator: assert property ( // R5
    s_r.st == ST_SLEEP |-> regulator_low_power_out == s_r.vlp && !sysclk_periph_run_out)
    else $error("regulator or clock state wrong in sleep");

  a_idle_clock_output_pin_run: assert property ( // R10
    s_r.st == ST_IDLE && clock_output_pin_cfg_in |-> clock_output_run_out && !cpu_step_out)
    else $error("clock output stopped in idle");

  // Wake-up, idle, peripheral, doze pacing, regulator and watchdog checks
  a_wake_vector: assert property ( // R4
    s_r.st == ST_RUN && s_r.vec_pend && cpu_step_out |=> vector_req_out)
    else $error("vector not requested after the first instruction");

  a_sleep_wake_clear: assert property ( // R3
    s_r.st == ST_SLEEP && (irq_pending_in || wdt_expiry_in) |=> wdt_clear_out)
    else $error("wake from sleep did not clear the watchdog");

  a_sleep_irq_resume: assert property ( // R3
    s_r.st == ST_SLEEP && irq_pending_in && !s_r.vlp |=> s_r.st == ST_RUN)
    else $error("interrupt did not wake from normal sleep at once");

  a_idle_cpu_halted: assert property ( // R8
    s_r.st == ST_IDLE |-> !cpu_step_out && sysclk_periph_run_out)
    else $error("idle did not halt the cpu or stopped peripherals");

  a_osc_periph_run: assert property ( // R9
    s_r.st == ST_SLEEP |-> intosc_periph_run_out && !cpu_step_out)
    else $error("oscillator peripherals stopped in sleep");

  a_lp_only_sleep: assert property ( // R5
    s_r.st != ST_SLEEP |-> !regulator_low_power_out)
    else $error("regulator low-power outside sleep");

  a_settle_no_step: assert property ( // R18
    s_r.st == ST_SETTLE |-> !cpu_step_out && !regulator_low_power_out)
    else $error("cpu ran during regulator settle");

  a_doze_step_gap: assert property ( // R15
    s_r.st == ST_RUN && s_r.doze_enable_bit && cpu_step_out |=> !s_r.doze_enable_bit || !cpu_step_out)
    else $error("doze ran two instruction cycles in a row");

  a_isr_doze_kept: assert property ( // R16
    isr_entry_in && !s_r.recover_on_irq && !wr_doze |=> s_r.doze_enable_bit == $past(s_r.doze_enable_bit))
    else $error("service entry changed doze without recover-on-interrupt");

  a_idle_doze_kept: assert property ( // R12
    s_r.st == ST_IDLE && irq_pending_in && !s_r.recover_on_irq && !wr_doze
    && !isr_entry_in && !isr_return_in |=> $stable(s_r.doze_enable_bit))
    else $error("idle wake changed doze without recover-on-interrupt");

  a_idle_holds: assert property ( // R11
    s_r.st == ST_IDLE && !irq_pending_in && !wdt_expiry_in |=> s_r.st == ST_IDLE)
    else $error("idle ended without a wake event");

  a_wdt_reset_awake: assert property ( // R13
    s_r.st != ST_RUN |=> !wdt_reset_out)
    else $error("watchdog reset requested while not running");
endmodule // power_down_mode_control

// ===== include/pdm_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PDM_MAP_SVH
`define PDM_MAP_SVH
`define VREG_OFF 6'h00
`define DOZE_OFF 6'h01
`define STAT_OFF 6'h02
`define VREG_LP_BIT 1
`define VREG_ONE_BIT 0
`define DOZE_IDLE_BIT 7
`define DOZE_EN_BIT 6
`define DOZE_ROI_BIT 5
`define DOZE_DOE_BIT 4
`define STAT_EXP_BIT 4
`define STAT_PD_BIT 3
`define EXPF_RST 1'b1
`define PDF_RST 1'b1
`define CLK_PERIOD_NS 10
`define REG_SETTLE_NS 2000
`define REG_SETTLE_CYC ((`REG_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== include/pdm_pkg.sv
// Types shared by the power-down mode controller
package pdm_pkg;
  typedef enum logic [3:0] {
    ST_RUN    = 4'b0001,
    ST_SLEEP  = 4'b0010,
    ST_IDLE   = 4'b0100,
    ST_SETTLE = 4'b1000
  } mode_type;
  typedef struct packed {
    mode_type   st;
    logic       vlp;
    logic       idle_sel;
    logic       doze_enable_bit;
    logic       recover_on_irq;
    logic       doe;
    logic [2:0] ratio;
    logic       expf;
    logic       pdf;
    logic       vec_pend;
    logic [7:0] settle;
    logic       ack;
    logic [7:0] dat;
    logic       wclr;
    logic       vreq;
    logic       wrst;
  } ctl_state_type;
endpackage

// ===== include/doze_if.sv
// Link between the mode controller and the instruction-cycle pacer
`timescale 1ns/1ns
interface doze_if;
  logic       enable;
  logic [2:0] ratio;
  logic       halted;
  logic       step;
  modport ctl   (output enable, output ratio, output halted, input step);
  modport pacer (input enable, input ratio, input halted, output step);
endinterface // doze_if

// ===== core/doze_pacer.sv
// Instruction-cycle pacer: one CPU cycle out of every 2^(ratio+1) in Doze
`timescale 1ns/1ns
module doze_pacer (
  input  wire logic clk_in,
  input  wire logic rst_in,
  doze_if.pacer     dz
);
  typedef struct packed {
    logic [7:0] cnt;
  } pace_state_type;

  pace_state_type s_r;
  pace_state_type s_nxt;
  logic [7:0]     last;

  // Terminal count is 2^(ratio+1) minus one
  assign last = 8'(({1'b0, 8'hFF} >> (3'h7 - dz.ratio)) & 9'h0FF);

  // Count slots while dozing, restart otherwise
  always_comb begin
    s_nxt = s_r;
    if (!dz.enable || dz.halted || s_r.cnt >= last) begin
      s_nxt.cnt = 8'h00;
    end else begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // No step while halted; full speed unless dozing, then only slot zero runs
  assign dz.step = !dz.halted && (!dz.enable || s_r.cnt == 8'h00); // R15
endmodule // doze_pacer

// ===== bench/core_model.sv
// Behavioural model of the processor core and interrupt sources
`timescale 1ns/1ns
module core_model (
  input  wire logic clk_in,
  output logic      halt_out,
  output logic      irq_out,
  output logic      gie_out,
  output logic      entry_out,
  output logic      return_out,
  output logic      expiry_out
);
  logic [3:0] ev_r;

  // One-cycle event pulses: halt, service entry, service return, watchdog expiry
  assign {expiry_out, return_out, entry_out, halt_out} = ev_r;

  // Quiet at time zero, global enable off so wakes resume in line
  initial begin
    ev_r = 4'h0;
    irq_out = 1'b0;
    gie_out = 1'b0;
  end

  // Raise one event for exactly one clock
  task automatic fire(input int k);
    @(posedge clk_in) ev_r[k] <= 1'b1;
    @(posedge clk_in) ev_r[k] <= 1'b0;
  endtask

  // Pending source with enable and flag both set, never the clock-switch one
  // Returns at the edge where the controller first samples the new level
  task automatic set_irq(input logic v);
    @(posedge clk_in) irq_out <= v;
    @(posedge clk_in);
  endtask

  // Global interrupt enable level
  task automatic set_gie(input logic v);
    @(posedge clk_in) gie_out <= v;
  endtask
endmodule // core_model

// ===== bench/power_down_mode_control_tb.sv
// Self-checking bench for the power-down mode controller
`timescale 1ns/1ns
`include "pdm_map.svh"
module power_down_mode_control_tb;
  import pdm_pkg::*;
  logic        clk_in, rst_in, cyc, stb, we, ack, step, vreq, wclr, wrst;
  logic        halt, irq, global_irq_enable, entry, ret, expiry, lp, sysrun, osrun, coutrun;
  logic [7:0]  adr;
  logic [31:0] dat_w, dat_r;
  mode_type    mode;
  int          bad_count, checks, cyc_n, n;
  logic [7:0]  q;
  logic        cfg;
  logic [3:0]  sel;

  core_model p (.clk_in(clk_in), .halt_out(halt), .irq_out(irq), .gie_out(global_irq_enable),
    .entry_out(entry), .return_out(ret), .expiry_out(expiry));

  power_down_mode_control dut (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(dat_w), .wb_dat_out(dat_r), .wb_ack_out(ack), .halt_exec_in(halt),
    .irq_pending_in(irq), .global_irq_enable_in(global_irq_enable), .isr_entry_in(entry),
    .isr_return_in(ret), .wdt_expiry_in(expiry), .clock_output_pin_cfg_in(cfg),
    .cpu_step_out(step), .vector_req_out(vreq), .wdt_clear_out(wclr),
    .wdt_reset_out(wrst), .regulator_low_power_out(lp),
    .sysclk_periph_run_out(sysrun), .intosc_periph_run_out(osrun),
    .clock_output_run_out(coutrun), .mode_out(mode));

  // Clock at 100 MHz
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Hang guard: the tests need well under 3000 cycles
  always @(posedge clk_in) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      bad_count = bad_count + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle; held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h000000, d};
    @(posedge clk_in);
    while (ack !== 1'b1) @(posedge clk_in);
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask

  task automatic mode_chk(input mode_type exp);
    #1 chk({4'h0, mode}, {4'h0, exp});
  endtask

  task automatic end_of_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {cyc, stb, we, adr, dat_w, bad_count, checks, cyc_n} = '0;
    sel = 4'hF;
    cfg = 1'b1;
    rst_in = 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_chk(8'h00, 8'h01);
    rd_chk(8'h08, 8'h18);
    rd_chk(8'h0C, 8'h00);
    bus(1'b1, 8'h00, 8'h03);
    rd_chk(8'h00, 8'h03);
    // Write without lane zero is dropped
    sel <= 4'hE;
    bus(1'b1, 8'h00, 8'h01);
    sel <= 4'hF;
    rd_chk(8'h00, 8'h03);
    $display("test registers done");
    // Interrupt pending before halt: halt does nothing
    p.set_irq(1'b1);
    p.fire(0);
    mode_chk(ST_RUN);
    chk({7'h0, wclr}, 8'h00);
    p.set_irq(1'b0);
    rd_chk(8'h08, 8'h18);
    $display("test race done");
    // Low-power Sleep, interrupt wake, settle delay
    p.fire(0);
    mode_chk(ST_SLEEP);
    chk({7'h0, wclr}, 8'h01);
    chk({7'h0, lp}, 8'h01);
    chk({6'h0, sysrun, osrun}, 8'h01);
    chk({7'h0, coutrun}, 8'h00);
    rd_chk(8'h08, 8'h10);
    p.set_irq(1'b1);
    mode_chk(ST_SETTLE);
    chk({7'h0, wclr}, 8'h01);
    n = 0;
    while (mode !== ST_RUN && n < 400) begin
      @(posedge clk_in);
      #1 n = n + 1;
    end
    chk(n[7:0], 8'(`REG_SETTLE_CYC));
    p.set_irq(1'b0);
    $display("test sleep done");
    // Idle with doze and recover-on-interrupt, ratio code 100
    bus(1'b1, 8'h04, 8'hE4);
    p.fire(0);
    mode_chk(ST_IDLE);
    chk({5'h0, sysrun, osrun, coutrun}, 8'h07);
    p.set_irq(1'b1);
    mode_chk(ST_RUN);
    p.set_irq(1'b0);
    rd_chk(8'h04, 8'hA4);
    // Watchdog expiry in Idle wakes without reset, doze kept
    bus(1'b1, 8'h04, 8'hC4);
    cfg <= 1'b0;
    p.fire(0);
    mode_chk(ST_IDLE);
    chk({7'h0, coutrun}, 8'h00);
    p.fire(3);
    mode_chk(ST_RUN);
    chk({7'h0, wrst}, 8'h00);
    rd_chk(8'h04, 8'hC4);
    rd_chk(8'h08, 8'h00);
    cfg <= 1'b1;
    $display("test idle done");
    // Doze 1:32 gives two steps in 64 cycles
    bus(1'b1, 8'h04, 8'h44);
    n = 0;
    repeat (64) begin
      @(posedge clk_in);
      #1 n = n + int'(step);
    end
    chk(n[7:0], 8'h02);
    // Service entry copies doze bit and clears it, return restores it
    bus(1'b1, 8'h04, 8'h64);
    p.fire(1);
    rd_chk(8'h04, 8'h34);
    p.fire(2);
    rd_chk(8'h04, 8'h74);
    $display("test doze done");
    // Normal Sleep with global enable set: wake, one instruction, then vector
    bus(1'b1, 8'h00, 8'h01);
    bus(1'b1, 8'h04, 8'h00);
    p.set_gie(1'b1);
    p.fire(0);
    mode_chk(ST_SLEEP);
    chk({7'h0, lp}, 8'h00);
    p.set_irq(1'b1);
    mode_chk(ST_RUN);
    chk({6'h0, wclr, vreq}, 8'h02);
    @(posedge clk_in);
    #1 chk({6'h0, wclr, vreq}, 8'h01);
    @(posedge clk_in);
    #1 chk({7'h0, vreq}, 8'h00);
    p.set_irq(1'b0);
    p.set_gie(1'b0);
    rd_chk(8'h08, 8'h10);
    $display("test vector done");
    end_of_test();
  end
endmodule // power_down_mode_control_tb
